//--- design/cclu_top.sv
// child count leaf unit: decrement and increment leaves on a control page counter
// assumes page map lookups and counter memory answer combinationally in the cycle asked
// Notes on behaviour
// - misaligned target page address gives general protection fault zero, checked after the privilege, leaf and segment/canonical checks
// - target address outside protected page cache gives enclave page fault
// - control address outside protected page cache gives enclave page fault
// - target page busy: zero flag set, conflict code returned, go to done
// - target page invalid in page map gives page fault
// - parent is owner for regular, thread, trimmed; own address for control page
// - parent differing from control page address gives general protection fault zero
// - decrement counter; on underflow restore it, set zero flag, underflow code
// - zero flag set only on conflict or underflow; success clears it, result zero
// - every non-faulting completion clears carry, parity, aux, overflow, sign flags
// - leaves are accepted only at privilege level zero
// - linear addresses use data segment base only, no override
// - protected mode: over segment limit or unusable segment faults
// - long mode: non-canonical address faults
// - increment counter, clear zero flag, result zero, no underflow check
`timescale 1ns/1ps
`default_nettype none
module cclu_top
  import cclu_pkg::*;
(
  input  wire logic                  core_clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  req_valid_i,
  output logic                       req_ready_o,
  input  wire logic [31:0]           leaf_select_i,
  input  wire logic [ADDR_W-1:0]     target_operand_register_i,
  input  wire logic [ADDR_W-1:0]     control_operand_register_i,
  input  wire logic [1:0]            priv_level_i,
  input  wire logic                  long_mode_i,
  input  wire logic [ADDR_W-1:0]     data_segment_base_i,
  input  wire logic [31:0]           data_segment_limit_i,
  input  wire logic                  data_segment_usable_i,
  output logic [ADDR_W-1:0]          target_lin_o,
  output logic [ADDR_W-1:0]          control_lin_o,
  input  wire logic                  target_in_cache_i,
  input  wire logic                  control_in_cache_i,
  input  wire logic                  target_busy_i,
  input  wire logic                  target_valid_i,
  input  wire logic [2:0]            target_page_type_i,
  input  wire logic [ADDR_W-1:0]     target_phys_i,
  input  wire logic [ADDR_W-1:0]     target_owner_phys_i,
  input  wire logic [ADDR_W-1:0]     control_phys_i,
  output logic                       cnt_wr_o,
  output logic [ADDR_W-1:0]          cnt_addr_o,
  output logic [CNT_W-1:0]           cnt_wdata_o,
  input  wire logic [CNT_W-1:0]      cnt_rdata_i,
  output logic                       done_o,
  output cclu_fault_t                fault_o,
  output logic [15:0]                fault_code_o,
  output logic                       fault_enclave_o,
  output logic [ADDR_W-1:0]          fault_addr_o,
  output logic [63:0]                result_register_o,
  output logic                       zero_flag_o,
  output logic                       clear_arith_flags_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_DONE} cclu_state_t;
  cclu_state_t state_q;
  logic [31:0]       leaf_q;
  logic [ADDR_W-1:0] tgt_eff_q;
  logic [ADDR_W-1:0] ctl_eff_q;
  logic [1:0]        priv_q;
  logic              tgt_bad;
  logic              ctl_bad;
  logic [ADDR_W-1:0] derived_parent_address;
  logic              type_ok;
  logic [CNT_W-1:0]  counter_scratch;

  // linear address from data segment base only
  assign target_lin_o  = data_segment_base_i + tgt_eff_q;
  assign control_lin_o = data_segment_base_i + ctl_eff_q;

  cclu_addr_check u_tgt_chk (
    .lin_addr_i   (target_lin_o),
    .eff_addr_i   (tgt_eff_q),
    .seg_limit_i  (data_segment_limit_i),
    .seg_usable_i (data_segment_usable_i),
    .long_mode_i  (long_mode_i),
    .addr_bad_o   (tgt_bad)
  );
  cclu_addr_check u_ctl_chk (
    .lin_addr_i   (control_lin_o),
    .eff_addr_i   (ctl_eff_q),
    .seg_limit_i  (data_segment_limit_i),
    .seg_usable_i (data_segment_usable_i),
    .long_mode_i  (long_mode_i),
    .addr_bad_o   (ctl_bad)
  );

  // parent selection by page type
  always_comb begin
    derived_parent_address = target_owner_phys_i;
    type_ok = 1'b1;
    case (target_page_type_i)
      REGULAR_PAGE_TYPE, THREAD_CONTROL_PAGE_TYPE, TRIMMED_PAGE_TYPE: begin
        derived_parent_address = target_owner_phys_i;
      end
      CONTROL_PAGE_TYPE: begin
        derived_parent_address = target_phys_i;
      end
      default: begin
        type_ok = 1'b0;
      end
    endcase
  end

  assign counter_scratch = cnt_rdata_i;
  assign req_ready_o = (state_q == ST_IDLE);
  assign cnt_addr_o  = derived_parent_address;

  // request capture
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      leaf_q    <= '0;
      tgt_eff_q <= '0;
      ctl_eff_q <= '0;
      priv_q    <= '0;
    end else if (req_valid_i && req_ready_o) begin
      leaf_q    <= leaf_select_i;
      tgt_eff_q <= target_operand_register_i;
      ctl_eff_q <= control_operand_register_i;
      priv_q    <= priv_level_i;
    end
  end

  // sequencer
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (req_valid_i) state_q <= ST_CHECK;
        ST_CHECK: state_q <= ST_DONE;
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // checks in documented order, counter update and completion
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      done_o              <= 1'b0;
      fault_o             <= FAULT_NONE;
      fault_code_o        <= '0;
      fault_enclave_o     <= 1'b0;
      fault_addr_o        <= '0;
      result_register_o   <= '0;
      zero_flag_o         <= 1'b0;
      clear_arith_flags_o <= 1'b0;
      cnt_wr_o            <= 1'b0;
      cnt_wdata_o         <= '0;
    end else begin
      done_o   <= 1'b0;
      cnt_wr_o <= 1'b0;
      if (state_q == ST_CHECK) begin
        done_o              <= 1'b1;
        fault_o             <= FAULT_NONE;
        fault_code_o        <= GP_ERROR_CODE;
        fault_enclave_o     <= 1'b0;
        fault_addr_o        <= '0;
        clear_arith_flags_o <= 1'b0;
        if (priv_q != PRIV_KERNEL ||
            (leaf_q != LEAF_DEC && leaf_q != LEAF_INC)) begin
          fault_o <= FAULT_UD;
        end else if (tgt_bad || ctl_bad) begin
          fault_o <= FAULT_GP;
        end else if (target_lin_o[PAGE_OFS_W-1:0] != '0) begin
          fault_o <= FAULT_GP;
        end else if (!target_in_cache_i) begin
          fault_o         <= FAULT_PF;
          fault_enclave_o <= 1'b1;
          fault_addr_o    <= target_lin_o;
        end else if (!control_in_cache_i) begin
          fault_o         <= FAULT_PF;
          fault_enclave_o <= 1'b1;
          fault_addr_o    <= control_lin_o;
        end else if (target_busy_i) begin
          zero_flag_o         <= 1'b1;
          result_register_o   <= PAGE_CONFLICT_CODE;
          clear_arith_flags_o <= 1'b1;
        end else if (!target_valid_i) begin
          fault_o         <= FAULT_PF;
          fault_enclave_o <= 1'b1;
          fault_addr_o    <= target_lin_o;
        end else if (!type_ok) begin
          fault_o         <= FAULT_PF;
          fault_enclave_o <= 1'b1;
          fault_addr_o    <= target_lin_o;
        end else if (derived_parent_address != control_phys_i) begin
          fault_o <= FAULT_GP;
        end else if (leaf_q == LEAF_DEC && counter_scratch == CNT_ZERO) begin
          // decrement would underflow: counter stays as it was
          zero_flag_o         <= 1'b1;
          result_register_o   <= COUNTER_UNDERFLOW_CODE;
          clear_arith_flags_o <= 1'b1;
        end else begin
          cnt_wr_o            <= 1'b1;
          cnt_wdata_o         <= (leaf_q == LEAF_INC) ? counter_scratch + CNT_ONE
                                                      : counter_scratch - CNT_ONE;
          zero_flag_o         <= 1'b0;
          result_register_o   <= RES_OK;
          clear_arith_flags_o <= 1'b1;
        end
      end
    end
  end

  property p_one_at_a_time;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (req_valid_i && req_ready_o) |=> !req_ready_o ##1 done_o;
  endproperty
  a_one_at_a_time: assert property (p_one_at_a_time) else $error("no completion");

  property p_zero_on_fail;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (done_o && fault_o == FAULT_NONE) |-> (zero_flag_o == (result_register_o != RES_OK));
  endproperty
  a_zero_on_fail: assert property (p_zero_on_fail) else $error("zero flag mismatch");

  property p_clear_flags;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      done_o |-> (clear_arith_flags_o == (fault_o == FAULT_NONE));
  endproperty
  a_clear_flags: assert property (p_clear_flags) else $error("flag clear wrong");

  property p_priv;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (state_q == ST_CHECK && priv_q != PRIV_KERNEL) |=> (fault_o != FAULT_NONE && !cnt_wr_o);
  endproperty
  a_priv: assert property (p_priv) else $error("leaf ran outside level zero");

  property p_align;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (state_q == ST_CHECK && priv_q == PRIV_KERNEL && !tgt_bad && !ctl_bad &&
       leaf_q[31:1] == '0 && target_lin_o[PAGE_OFS_W-1:0] != '0) |=> (fault_o == FAULT_GP);
  endproperty
  a_align: assert property (p_align) else $error("misaligned target not faulted");

  property p_conflict;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (done_o && result_register_o == PAGE_CONFLICT_CODE && fault_o == FAULT_NONE)
        |-> (zero_flag_o && !cnt_wr_o);
  endproperty
  a_conflict: assert property (p_conflict) else $error("conflict wrote counter");

  property p_underflow;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (done_o && result_register_o == COUNTER_UNDERFLOW_CODE) |-> !cnt_wr_o;
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow changed counter");

  property p_write_only_ok;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      cnt_wr_o |-> (done_o && fault_o == FAULT_NONE && result_register_o == RES_OK);
  endproperty
  a_write_only_ok: assert property (p_write_only_ok) else $error("stray counter write");
endmodule
`default_nettype wire

//--- design/cclu_pkg.sv
// package for the child count leaf unit: leaf indices, result codes, fault classes
// assumes nothing beyond a systemverilog-2012 tool
`default_nettype none
package cclu_pkg;
  localparam int           ADDR_W         = 64;
  localparam int           CNT_W          = 64;
  localparam int           PAGE_OFS_W     = 12;
  localparam logic [31:0]  LEAF_DEC       = 32'h0000_0000;
  localparam logic [31:0]  LEAF_INC       = 32'h0000_0001;
  localparam logic [63:0]  RES_OK         = 64'h0000_0000_0000_0000;
  localparam logic [63:0]  PAGE_CONFLICT_CODE     = 64'h0000_0000_0000_000d;
  localparam logic [63:0]  COUNTER_UNDERFLOW_CODE = 64'h0000_0000_0000_0023;
  localparam logic [15:0]  GP_ERROR_CODE  = 16'h0000;
  localparam logic [1:0]   PRIV_KERNEL    = 2'h0;
  localparam logic [CNT_W-1:0] CNT_ONE    = 64'h0000_0000_0000_0001;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 64'h0000_0000_0000_0000;
  localparam int           CANON_MSB      = 47;

  typedef enum logic [2:0] {
    REGULAR_PAGE_TYPE        = 3'h0,
    THREAD_CONTROL_PAGE_TYPE = 3'h1,
    TRIMMED_PAGE_TYPE        = 3'h2,
    CONTROL_PAGE_TYPE        = 3'h3,
    OTHER_PAGE_TYPE          = 3'h4
  } cclu_page_type_t;

  typedef enum logic [1:0] {
    FAULT_NONE = 2'h0,
    FAULT_GP   = 2'h1,
    FAULT_PF   = 2'h2,
    FAULT_UD   = 2'h3
  } cclu_fault_t;
endpackage
`default_nettype wire

//--- design/cclu_addr_check.sv
// operand address checker: data segment limit, usability, canonical form
// assumes the linear address is already formed from the data segment base
`timescale 1ns/1ps
`default_nettype none
module cclu_addr_check
  import cclu_pkg::*;
(
  input  wire logic [ADDR_W-1:0] lin_addr_i,
  input  wire logic [ADDR_W-1:0] eff_addr_i,
  input  wire logic [31:0]       seg_limit_i,
  input  wire logic              seg_usable_i,
  input  wire logic              long_mode_i,
  output logic                   addr_bad_o
);
  logic canon_ok;
  logic limit_ok;
  // upper bits must all equal bit 47
  assign canon_ok = (lin_addr_i[ADDR_W-1:CANON_MSB] == '0) ||
                    (lin_addr_i[ADDR_W-1:CANON_MSB] == '1);
  assign limit_ok = (eff_addr_i[ADDR_W-1:32] == '0) && (eff_addr_i[31:0] <= seg_limit_i);
  assign addr_bad_o = long_mode_i ? !canon_ok : (!seg_usable_i || !limit_ok);
endmodule
`default_nettype wire

//--- verification/cclu_cnt_model.sv
// counter memory model for the enclave control page at address PARENT
// assumes the unit writes the counter with a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module cclu_cnt_model #(
  parameter logic [63:0] PARENT = 64'h0000_0000_0000_a000
) (
  input  wire logic        core_clk_i,
  input  wire logic        load_i,
  input  wire logic [63:0] load_val_i,
  input  wire logic        cnt_wr_i,
  input  wire logic [63:0] cnt_addr_i,
  input  wire logic [63:0] cnt_wdata_i,
  output logic [63:0]      cnt_rdata_o,
  output logic [63:0]      cnt_o
);
  logic [63:0] cnt_q;
  always_ff @(posedge core_clk_i) begin
    if (load_i) begin
      cnt_q <= load_val_i;
    end else if (cnt_wr_i && cnt_addr_i == PARENT) begin
      cnt_q <= cnt_wdata_i;
    end
  end
  // a wrong page returns the inverse, so a bad address never reads right
  assign cnt_rdata_o = (cnt_addr_i == PARENT) ? cnt_q : ~cnt_q;
  assign cnt_o       = cnt_q;
endmodule
`default_nettype wire

//--- verification/cclu_top_tb.sv
// testbench for the child count leaf unit: issues leaves, checks completions
// assumes one request per done and the counter model at the parent address
`timescale 1ns/1ps
`default_nettype none
module cclu_top_tb
  import cclu_pkg::*;
;
  logic        clk, rst, vld, lm, usable, tic, cic, busy, tval, load;
  logic        rdy, wr, done, fenc, zf, clr;
  logic [31:0] leaf, lim;
  logic [1:0]  priv;
  logic [2:0]  ptype;
  logic [15:0] fcode;
  logic [63:0] base, tea, cea, tphys, ophys, cphys, loadv;
  logic [63:0] tlin, clin, caddr, wdata, rdata, fa, res, cnt;
  cclu_fault_t fault;
  int          err_count, check_count;

  cclu_top dut_u (.core_clk_i(clk), .sys_rst_i(rst), .req_valid_i(vld), .req_ready_o(rdy),
    .leaf_select_i(leaf), .target_operand_register_i(tea), .control_operand_register_i(cea),
    .priv_level_i(priv), .long_mode_i(lm), .data_segment_base_i(base),
    .data_segment_limit_i(lim), .data_segment_usable_i(usable), .target_lin_o(tlin),
    .control_lin_o(clin), .target_in_cache_i(tic), .control_in_cache_i(cic),
    .target_busy_i(busy), .target_valid_i(tval), .target_page_type_i(ptype),
    .target_phys_i(tphys), .target_owner_phys_i(ophys), .control_phys_i(cphys),
    .cnt_wr_o(wr), .cnt_addr_o(caddr), .cnt_wdata_o(wdata), .cnt_rdata_i(rdata),
    .done_o(done), .fault_o(fault), .fault_code_o(fcode), .fault_enclave_o(fenc),
    .fault_addr_o(fa), .result_register_o(res), .zero_flag_o(zf),
    .clear_arith_flags_o(clr));
  cclu_cnt_model mdl_u (.core_clk_i(clk), .load_i(load), .load_val_i(loadv), .cnt_wr_i(wr),
    .cnt_addr_i(caddr), .cnt_wdata_i(wdata), .cnt_rdata_o(rdata), .cnt_o(cnt));

  task automatic give_verdict;
    $display("errors %0d, checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic dflt;
    lm = 1'b1; usable = 1'b1; lim = 32'hffff_ffff; priv = PRIV_KERNEL;
    base = 64'h1000; tea = 64'h2000; cea = 64'h3000; tic = 1'b1; cic = 1'b1;
    busy = 1'b0; tval = 1'b1; ptype = REGULAR_PAGE_TYPE;
    tphys = 64'hb000; ophys = 64'ha000; cphys = 64'ha000;
  endtask

  task automatic setc(input logic [63:0] v);
    load = 1'b1;
    loadv = v;
    @(posedge clk); #1;
    load = 1'b0;
  endtask

  // er doubles as the expected fault address for page faults
  task automatic go(input logic [31:0] l, input logic [1:0] ef, input logic [63:0] er,
                    input logic ez, input logic [63:0] ec);
    int n;
    chk("ready", 64'h1, {63'h0, rdy});
    leaf = l;
    vld = 1'b1;
    @(posedge clk); #1;
    vld = 1'b0;
    n = 0;
    do begin
      @(posedge clk); #1;
      n++;
    end while (done !== 1'b1 && n < 8);
    if (done !== 1'b1) begin
      err_count++;
      give_verdict;
    end else begin
      chk("latency", 64'h1, 64'(n));
      chk("fault", {62'h0, ef}, {62'h0, fault});
      if (ef == FAULT_NONE) begin
        chk("result", er, res);
        chk("zero flag", {63'h0, ez}, {63'h0, zf});
        chk("flag clear", 64'h1, {63'h0, clr});
      end else if (ef == FAULT_GP) begin
        chk("gp code", {48'h0, GP_ERROR_CODE}, {48'h0, fcode});
      end else if (ef == FAULT_PF) begin
        chk("fault addr", er, fa);
        chk("enclave", 64'h1, {63'h0, fenc});
      end
      // let the done cycle pass so the unit is idle for the next call
      @(posedge clk); #1;
      if (ef == FAULT_NONE) begin
        chk("counter", ec, cnt);
      end
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #200000;
    err_count++;
    give_verdict;
  end

  initial begin
    rst = 1'b1; vld = 1'b0; leaf = 32'h0; load = 1'b0; loadv = 64'h0;
    err_count = 0; check_count = 0;
    dflt;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    setc(64'h5);
    go(LEAF_INC, FAULT_NONE, RES_OK, 1'b0, 64'h6);
    chk("target lin", 64'h3000, tlin);
    chk("control lin", 64'h4000, clin);
    go(LEAF_DEC, FAULT_NONE, RES_OK, 1'b0, 64'h5);
    setc(64'h0);
    go(LEAF_DEC, FAULT_NONE, COUNTER_UNDERFLOW_CODE, 1'b1, 64'h0);
    busy = 1'b1;
    go(LEAF_INC, FAULT_NONE, PAGE_CONFLICT_CODE, 1'b1, 64'h0);
    dflt; tea = 64'h2010; tic = 1'b0;
    go(LEAF_DEC, FAULT_GP, 64'h0, 1'b0, 64'h0);
    dflt; tic = 1'b0;
    go(LEAF_DEC, FAULT_PF, 64'h3000, 1'b0, 64'h0);
    dflt; cic = 1'b0;
    go(LEAF_INC, FAULT_PF, 64'h4000, 1'b0, 64'h0);
    dflt; tval = 1'b0;
    go(LEAF_DEC, FAULT_PF, 64'h3000, 1'b0, 64'h0);
    dflt; ptype = 3'h4;
    go(LEAF_INC, FAULT_PF, 64'h3000, 1'b0, 64'h0);
    dflt; ptype = CONTROL_PAGE_TYPE; tphys = 64'ha000; ophys = 64'hc000;
    setc(64'h7);
    go(LEAF_INC, FAULT_NONE, RES_OK, 1'b0, 64'h8);
    dflt; ophys = 64'hc000;
    go(LEAF_DEC, FAULT_GP, 64'h0, 1'b0, 64'h0);
    dflt; priv = 2'h3;
    go(LEAF_INC, FAULT_UD, 64'h0, 1'b0, 64'h0);
    dflt; tea = 64'h0000_8000_0000_0000;
    go(LEAF_INC, FAULT_GP, 64'h0, 1'b0, 64'h0);
    dflt; lm = 1'b0; usable = 1'b0;
    go(LEAF_DEC, FAULT_GP, 64'h0, 1'b0, 64'h0);
    dflt; lm = 1'b0; lim = 32'h0000_2fff;
    go(LEAF_INC, FAULT_GP, 64'h0, 1'b0, 64'h0);
    dflt;
    go(32'h0000_0002, FAULT_UD, 64'h0, 1'b0, 64'h0);
    rst = 1'b1;
    @(posedge clk); #1;
    rst = 1'b0;
    chk("done after reset", 64'h0, {63'h0, done});
    chk("fault after reset", {62'h0, FAULT_NONE}, {62'h0, fault});
    go(LEAF_INC, FAULT_NONE, RES_OK, 1'b0, 64'h9);
    give_verdict;
  end
endmodule
`default_nettype wire
